// File: hdl/usis_defines.vh
// Register offsets, bit positions and reset values of the interrupt and status block.
`ifndef USIS_DEFINES_VH
`define USIS_DEFINES_VH
// ==========================================================
// Register word offsets (byte addresses, one aligned word each)
`define USIS_ADDR_W 8
`define USIS_OFS_IER 8'h08
`define USIS_OFS_IDR 8'h0c
`define USIS_OFS_IMR 8'h10
`define USIS_OFS_CSR 8'h14
`define USIS_OFS_RHR 8'h18
`define USIS_OFS_CMD 8'h00
`define USIS_OFS_CTL 8'h04
`define USIS_OFS_TOV 8'h24
// ==========================================================
// Layout of enable, disable, mask and status, shared except the Manchester bit (20 in mask, 24 in status)
`define USIS_B_RECEIVER_READY_FLAG 0
`define USIS_B_TRANSMITTER_READY_FLAG 1
`define USIS_B_BRK 2
`define USIS_B_RECEIVE_DMA_END 3
`define USIS_B_TRANSMIT_DMA_END 4
`define USIS_B_OVR 5
`define USIS_B_FRM 6
`define USIS_B_PAR 7
`define USIS_B_TMO 8
`define USIS_B_TXEMP 9
`define USIS_B_ITER 10
`define USIS_B_TRANSMIT_DMA_BUFFER_EMPTY 11
`define USIS_B_RECEIVE_DMA_BUFFER_FULL 12
`define USIS_B_NACK 13
`define USIS_B_RING_CHANGE_FLAG 16
`define USIS_B_CLEAR_SEND_CHANGE_FLAG 19
`define USIS_B_MAN_IMR 20
`define USIS_B_RI 20
`define USIS_B_CTS 23
`define USIS_B_MAN_CSR 24
`define USIS_IMR_VALID 32'h001f3fff
// ==========================================================
// Command register bits
`define USIS_C_RSTRX 2
`define USIS_C_RSTTX 3
`define USIS_C_RXEN 4
`define USIS_C_RXDIS 5
`define USIS_C_TXEN 6
`define USIS_C_TXDIS 7
`define USIS_C_RESET_STATUS_COMMAND 8
`define USIS_C_START_BREAK_COMMAND 9
`define USIS_C_START_TIMEOUT_COMMAND 11
`define USIS_C_RESET_ITERATIONS_COMMAND 13
`define USIS_C_RESET_NONACK_COMMAND 14
// ==========================================================
// Widths and reset values
`define USIS_TO_W 16
`define USIS_CHR_W 9
`define USIS_RHR_SYNC 15
`define USIS_ZERO32 32'h00000000
`define USIS_TO_ZERO 16'h0000
`endif

// File: hdl/usis_top.v
// Interrupt enable, disable and mask logic with the channel status flags of a serial channel.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "usis_defines.vh"

// Behaviour
// RL1: Writing one to an enable bit sets that mask bit; zero leaves it.
// RL2: Writing one to a disable bit clears that mask bit; zero leaves it.
// RL3: Mask register reads one for each enabled source, zero otherwise.
// RL4: Enable, disable and mask share bits 0-13 and 16-20 layout.
// RL5: Receiver ready sets on received character, clears on holding read or disable.
// RL6: Transmitter ready low while character held, break pending, or transmitter disabled.
// RL7: Break flag sets on break or end of break until reset-status.
// RL8: Four status bits mirror the DMA channel signals without latching.
// RL9: Overrun flag sticky until reset-status command.
// RL10: Framing flag sets on low stop bit, sticky until reset-status.
// RL11: Parity flag sets on parity error, sticky until reset-status.
// RL12: Time-out flag sets on expiry after start-time-out; zero when value zero.
// RL13: Transmitter empty only when holding and shift registers empty and enabled.
// RL14: Iteration flag sets at maximum repetitions until reset-iterations.
// RL15: Non-acknowledge flag sticky until reset-non-acknowledge command.
// RL16: Input change flags set on pin level change, clear on status read.
// RL17: Status bits 20 to 23 show live modem input levels.
// RL18: Manchester error flag in bit 24 sticky until reset-status.
// RL19: Start-time-out arms the counter for the next character and clears time-out.
// RL20: Interrupt output high while any masked-in source is active.
// RL21: Reset-status clears break, overrun, framing, parity and Manchester flags together.
module usis_top
(
  input wire SYS_CLK,
  input wire NRST,
  input wire [`USIS_ADDR_W-1:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  output reg IRQ,
  input wire RX_CHAR_DONE,
  input wire [`USIS_CHR_W-1:0] RX_CHAR,
  input wire RX_SYNC_KIND,
  input wire RX_ACTIVE,
  input wire TX_HOLD_FULL,
  input wire TX_SHIFT_BUSY,
  input wire BREAK_EVT,
  input wire OVERRUN_EVT,
  input wire FRAMING_EVT,
  input wire PARITY_EVT,
  input wire TIMEOUT_EXPIRE,
  input wire ITER_MAX_EVT,
  input wire NACK_EVT,
  input wire MANCH_EVT,
  input wire [3:0] DMA_SIG,
  input wire [3:0] MODEM_PINS,
  output reg TO_ARM,
  output reg BREAK_REQ,
  output reg RX_ENABLED,
  output reg TX_ENABLED,
  output reg [`USIS_TO_W-1:0] TIMEOUT_VALUE
);

  // ==========================================================
  // Bus decode
  wire wr_ier = WR && (ADDR == `USIS_OFS_IER);
  wire wr_idr = WR && (ADDR == `USIS_OFS_IDR);
  wire wr_cmd = WR && (ADDR == `USIS_OFS_CMD);
  wire wr_tov = WR && (ADDR == `USIS_OFS_TOV);
  wire rd_csr = RD && (ADDR == `USIS_OFS_CSR);
  wire rd_rhr = RD && (ADDR == `USIS_OFS_RHR);
  wire cmd_reset_status_command = wr_cmd && WDATA[`USIS_C_RESET_STATUS_COMMAND];
  wire cmd_start_timeout_command = wr_cmd && WDATA[`USIS_C_START_TIMEOUT_COMMAND];
  wire cmd_reset_iterations_command = wr_cmd && WDATA[`USIS_C_RESET_ITERATIONS_COMMAND];
  wire cmd_reset_nonack_command = wr_cmd && WDATA[`USIS_C_RESET_NONACK_COMMAND];
  wire cmd_start_break_command = wr_cmd && WDATA[`USIS_C_START_BREAK_COMMAND];
  wire rx_on_cmd = wr_cmd && WDATA[`USIS_C_RXEN] && !WDATA[`USIS_C_RXDIS];
  wire rx_off_cmd = wr_cmd && (WDATA[`USIS_C_RXDIS] || WDATA[`USIS_C_RSTRX]);
  wire tx_on_cmd = wr_cmd && WDATA[`USIS_C_TXEN] && !WDATA[`USIS_C_TXDIS];
  wire tx_off_cmd = wr_cmd && (WDATA[`USIS_C_TXDIS] || WDATA[`USIS_C_RSTTX]);

  // ==========================================================
  // Two-flop synchronisers for the pins from outside the clock domain.
  reg [3:0] modem_s1_ff;
  reg [3:0] modem_s2_ff;
  reg [3:0] modem_old_ff;
  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      modem_s1_ff <= 4'h0;
      modem_s2_ff <= 4'h0;
      modem_old_ff <= 4'h0;
    end
    else
    begin
      modem_s1_ff <= MODEM_PINS;
      modem_s2_ff <= modem_s1_ff;
      modem_old_ff <= modem_s2_ff;
    end
  end

  // ==========================================================
  // Mask register; enable and disable never target the same cycle as both strobes are exclusive.
  reg [31:0] mask_ff;
  wire [31:0] nxt_mask = (mask_ff | (wr_ier ? WDATA : `USIS_ZERO32)) // see RL1
                         & ~(wr_idr ? WDATA : `USIS_ZERO32); // see RL2
  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
      mask_ff <= `USIS_ZERO32;
    else
      mask_ff <= nxt_mask & `USIS_IMR_VALID; // see RL4
  end

  // ==========================================================
  // Sticky flags and control registers; each group below has a process of its own.
  // Throughout, except for the receiver and transmitter enables, a set in the same cycle as its clear wins, so no event is lost.
  reg receiver_ready_flag_ff;
  reg rx_was_busy_ff;
  reg brk_ff;
  reg ovr_ff;
  reg frm_ff;
  reg par_ff;
  reg tmo_ff;
  reg iter_ff;
  reg nack_ff;
  reg man_ff;
  reg brk_pend_ff;
  reg [3:0] chg_ff;
  reg [`USIS_CHR_W-1:0] rx_char_ff;
  reg rx_sync_ff;
  // A level change after the second synchroniser stage counts as one input change per pin.
  wire [3:0] pin_change = modem_s2_ff ^ modem_old_ff;
  // A zero time-out value switches the receiver time-out off altogether.
  wire tov_zero = (TIMEOUT_VALUE == `USIS_TO_ZERO);
  // Nothing is left to send: holding and shift registers are both empty.
  wire tx_drained = !TX_HOLD_FULL && !TX_SHIFT_BUSY;

  // ==========================================================
  // Receiver and transmitter enables.
  // Disable wins over enable in one write, so a confused command leaves the channel quiet.
  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      RX_ENABLED <= 1'b0;
      TX_ENABLED <= 1'b0;
      rx_was_busy_ff <= 1'b0;
    end
    else
    begin
      // A disable while a character is under way is remembered for the re-enable.
      if (rx_off_cmd)
      begin
        RX_ENABLED <= 1'b0;
        rx_was_busy_ff <= RX_ACTIVE;
      end
      else if (rx_on_cmd)
      begin
        RX_ENABLED <= 1'b1;
        rx_was_busy_ff <= 1'b0;
      end
      // The transmitter has no memory of its own state across a disable.
      if (tx_off_cmd)
        TX_ENABLED <= 1'b0;
      else if (tx_on_cmd)
        TX_ENABLED <= 1'b1;
    end
  end

  // ==========================================================
  // Receiver ready and the captured character.
  // A character strobe while the receiver is off is dropped, so stale data never shows.
  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      receiver_ready_flag_ff <= 1'b0;
      rx_char_ff <= {`USIS_CHR_W{1'b0}};
      rx_sync_ff <= 1'b0;
    end
    else
    begin
      if (RX_CHAR_DONE && RX_ENABLED)
      begin
        receiver_ready_flag_ff <= 1'b1; // see RL5
        rx_char_ff <= RX_CHAR;
        rx_sync_ff <= RX_SYNC_KIND;
      end
      else if (!RX_ENABLED && rx_on_cmd && rx_was_busy_ff)
        receiver_ready_flag_ff <= 1'b1; // see RL5
      else if (rd_rhr || !RX_ENABLED || rx_off_cmd)
        receiver_ready_flag_ff <= 1'b0; // see RL5
    end
  end

  // ==========================================================
  // Line error flags, cleared together by the reset-status command.
  // The event term stands outside the clear, so an error in the clearing cycle is kept.
  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      brk_ff <= 1'b0;
      ovr_ff <= 1'b0;
      frm_ff <= 1'b0;
      par_ff <= 1'b0;
      man_ff <= 1'b0;
    end
    else
    begin
      brk_ff <= BREAK_EVT | (brk_ff & ~cmd_reset_status_command); // see RL7
      ovr_ff <= OVERRUN_EVT | (ovr_ff & ~cmd_reset_status_command); // see RL9
      frm_ff <= FRAMING_EVT | (frm_ff & ~cmd_reset_status_command); // see RL10
      par_ff <= PARITY_EVT | (par_ff & ~cmd_reset_status_command); // see RL11
      man_ff <= MANCH_EVT | (man_ff & ~cmd_reset_status_command); // see RL18 see RL21
    end
  end

  // ==========================================================
  // Repetition and non-acknowledge flags, each with a clear command of its own.
  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      iter_ff <= 1'b0;
      nack_ff <= 1'b0;
    end
    else
    begin
      iter_ff <= ITER_MAX_EVT | (iter_ff & ~cmd_reset_iterations_command); // see RL14
      nack_ff <= NACK_EVT | (nack_ff & ~cmd_reset_nonack_command); // see RL15
    end
  end

  // ==========================================================
  // Receiver time-out flag.
  // The flag is held low while the value is zero, so switching off also hides an old expiry.
  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
      tmo_ff <= 1'b0;
    else
      tmo_ff <= (TIMEOUT_EXPIRE & ~tov_zero) // see RL12
                | (tmo_ff & ~cmd_start_timeout_command & ~tov_zero); // see RL19
  end

  // ==========================================================
  // Time-out value and the arm request to the time-out counter.
  // The arm request stands until the next character starts the counter.
  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      TO_ARM <= 1'b0;
      TIMEOUT_VALUE <= `USIS_TO_ZERO;
    end
    else
    begin
      if (cmd_start_timeout_command)
        TO_ARM <= 1'b1; // see RL19
      else if (RX_CHAR_DONE)
        TO_ARM <= 1'b0;
      if (wr_tov)
        TIMEOUT_VALUE <= WDATA[`USIS_TO_W-1:0];
    end
  end

  // ==========================================================
  // Break request.
  // A break pends until the transmitter has drained; it is ignored while the transmitter is off.
  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      brk_pend_ff <= 1'b0;
      BREAK_REQ <= 1'b0;
    end
    else
    begin
      if (cmd_start_break_command && TX_ENABLED)
        brk_pend_ff <= 1'b1; // see RL6
      else if (tx_drained)
        brk_pend_ff <= 1'b0;
      BREAK_REQ <= brk_pend_ff && tx_drained;
    end
  end

  // ==========================================================
  // Input change flags.
  // They clear on a status read unless a change lands in that cycle, so no edge is lost.
  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
      chg_ff <= 4'h0;
    else
      chg_ff <= pin_change | (chg_ff & {4{~rd_csr}}); // see RL16
  end

  // ==========================================================
  // Status assembly; live bits are read straight, sticky ones from their flops.
  wire transmitter_ready_flag = TX_ENABLED && !TX_HOLD_FULL && !brk_pend_ff; // see RL6
  wire txemp = TX_ENABLED && !TX_HOLD_FULL && !TX_SHIFT_BUSY; // see RL13
  reg [31:0] status;
  always @*
  begin
    status = `USIS_ZERO32;
    status[`USIS_B_RECEIVER_READY_FLAG] = receiver_ready_flag_ff;
    status[`USIS_B_TRANSMITTER_READY_FLAG] = transmitter_ready_flag;
    status[`USIS_B_BRK] = brk_ff;
    status[`USIS_B_RECEIVE_DMA_END] = DMA_SIG[0]; // see RL8
    status[`USIS_B_TRANSMIT_DMA_END] = DMA_SIG[1]; // see RL8
    status[`USIS_B_OVR] = ovr_ff;
    status[`USIS_B_FRM] = frm_ff;
    status[`USIS_B_PAR] = par_ff;
    status[`USIS_B_TMO] = tmo_ff & ~tov_zero; // see RL12
    status[`USIS_B_TXEMP] = txemp;
    status[`USIS_B_ITER] = iter_ff;
    status[`USIS_B_TRANSMIT_DMA_BUFFER_EMPTY] = DMA_SIG[2]; // see RL8
    status[`USIS_B_RECEIVE_DMA_BUFFER_FULL] = DMA_SIG[3]; // see RL8
    status[`USIS_B_NACK] = nack_ff;
    status[`USIS_B_CLEAR_SEND_CHANGE_FLAG:`USIS_B_RING_CHANGE_FLAG] = chg_ff;
    status[`USIS_B_CTS:`USIS_B_RI] = modem_s2_ff; // see RL17
    status[`USIS_B_MAN_CSR] = man_ff;
  end

  // Interrupt sources in the mask layout; Manchester moves from bit 24 to bit 20.
  wire [31:0] sources = {11'h000, man_ff, status[`USIS_B_CLEAR_SEND_CHANGE_FLAG:0]};

  // ==========================================================
  // Read data and interrupt output, both registered.
  // Read data stand for exactly one cycle after the strobe and are zero otherwise,
  // so a master that samples late sees zero rather than a stale word.
  reg [31:0] nxt_rdata;
  always @*
  begin
    nxt_rdata = `USIS_ZERO32;
    if (RD)
    begin
      case (ADDR)
        `USIS_OFS_IMR: nxt_rdata = mask_ff; // see RL3
        `USIS_OFS_CSR: nxt_rdata = status;
        `USIS_OFS_RHR: nxt_rdata = {16'h0000, rx_sync_ff, 6'h00, rx_char_ff};
        `USIS_OFS_CTL: nxt_rdata = {30'h0, TX_ENABLED, RX_ENABLED};
        `USIS_OFS_TOV: nxt_rdata = {16'h0000, TIMEOUT_VALUE};
        default: nxt_rdata = `USIS_ZERO32;
      endcase
    end
  end

  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      RDATA <= `USIS_ZERO32;
      IRQ <= 1'b0;
    end
    else
    begin
      RDATA <= nxt_rdata;
      IRQ <= |(sources & mask_ff); // see RL20
    end
  end

endmodule // usis_top

// File: tb/usart_interrupt_status_test.sv
// Self-checking bench for the interrupt and status block.
`timescale 1ns/1ps
`include "usis_defines.vh"
// ==========================================================
// Bench
module usart_interrupt_status_test;
  localparam [63:0] POS = 64'h180d0a0807060502;
  localparam [31:0] CMDS = 32'h0b0e0d08;
  localparam [127:0] CLRS = 128'h00000100_00002000_00000400_010000e4;
  reg sys_clk, nrst, wr, rd, rx_active, tx_hold, tx_shift;
  reg [7:0] addr, evt;
  reg [31:0] wdata, seed, mask, sticky, rxr, tx_m;
  reg [3:0] dma, chg;
  wire [31:0] rdata;
  wire irq, rx_done, rx_sync, to_arm, brk_req;
  wire [8:0] rx_chr;
  wire [3:0] pins;
  integer i, failures, checks_done;
  usis_top usis_top_i
  (
    .SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
    .RX_CHAR_DONE(rx_done), .RX_CHAR(rx_chr), .RX_SYNC_KIND(rx_sync), .RX_ACTIVE(rx_active),
    .TX_HOLD_FULL(tx_hold), .TX_SHIFT_BUSY(tx_shift), .BREAK_EVT(evt[0]), .OVERRUN_EVT(evt[1]),
    .FRAMING_EVT(evt[2]), .PARITY_EVT(evt[3]), .TIMEOUT_EXPIRE(evt[4]), .ITER_MAX_EVT(evt[5]),
    .NACK_EVT(evt[6]), .MANCH_EVT(evt[7]), .DMA_SIG(dma), .MODEM_PINS(pins), .TO_ARM(to_arm),
    .BREAK_REQ(brk_req), .RX_ENABLED(), .TX_ENABLED(), .TIMEOUT_VALUE()
  );
  usis_peer usis_peer_i (.clk(sys_clk), .done(rx_done), .chr(rx_chr), .sync(rx_sync), .pins(pins));
  // 40 MHz clock.
  always #12.5 sys_clk = ~sys_clk;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Model status word: sticky flags, readiness, live dma and modem lines.
  function [31:0] csr_exp(input integer u);
    csr_exp = sticky | rxr | {8'h0, pins, chg, 3'h0, dma[3:2], 6'h0, dma[1:0], 3'h0}
      | {22'h0, tx_m[0] & ~tx_hold & ~tx_shift, 7'h0, tx_m[0] & ~tx_hold & ~tx_m[1], 1'b0};
  endfunction
  task check(input [31:0] g, input [31:0] e);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
  begin
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  end
  endtask
  // Status reads take their expectation at the issuing edge, then clear the change flags.
  task rd_chk(input [7:0] a, input [31:0] e);
  begin
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    if (a == `USIS_OFS_CSR)
      e = csr_exp(0);
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    check(rdata, e);
    if (a == `USIS_OFS_CSR)
      chg = 4'h0;
    @(posedge sys_clk);
  end
  endtask
  task pulse(input integer k);
  begin
    @(posedge sys_clk);
    evt <= 8'h1 << k;
    @(posedge sys_clk);
    evt <= 8'h0;
    sticky = sticky | (32'h1 << POS[k*8 +: 8]);
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // Main flow: mask, sticky flags, interrupt, modem, receiver, transmitter.
  initial
  begin
    {sys_clk, nrst, wr, rd, rx_active, tx_hold, tx_shift} = 7'h0;
    {addr, evt, dma, chg} = 24'h0;
    {wdata, mask, sticky, rxr, tx_m} = 160'h0;
    failures = 0;
    checks_done = 0;
    seed = 32'h58d9;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    for (i = 0; i < 10; i = i + 1)
    begin
      seed = lfsr(seed);
      dma <= seed[7:4];
      wr_reg(i[0] ? `USIS_OFS_IDR : `USIS_OFS_IER, seed);
      mask = i[0] ? mask & ~seed : (mask | seed) & `USIS_IMR_VALID;
      rd_chk(`USIS_OFS_IMR, mask);
    end
    wr_reg(`USIS_OFS_IMR, 32'hffffffff);
    rd_chk(`USIS_OFS_IMR, mask);
    rd_chk(8'h3c, 32'h0);
    wr_reg(`USIS_OFS_TOV, 32'h5);
    rd_chk(`USIS_OFS_TOV, 32'h5);
    wr_reg(`USIS_OFS_CMD, 32'h1 << `USIS_C_START_TIMEOUT_COMMAND);
    @(negedge sys_clk);
    check({31'h0, to_arm}, 32'h1);
    for (i = 0; i < 8; i = i + 1)
    begin
      pulse(i);
      rd_chk(`USIS_OFS_CSR, 32'h0);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      wr_reg(`USIS_OFS_CMD, 32'h1 << CMDS[i*8 +: 8]);
      sticky = sticky & ~CLRS[i*32 +: 32];
      rd_chk(`USIS_OFS_CSR, 32'h0);
    end
    wr_reg(`USIS_OFS_TOV, 32'h0);
    pulse(4);
    sticky = 32'h0;
    rd_chk(`USIS_OFS_CSR, 32'h0);
    wr_reg(`USIS_OFS_IDR, `USIS_IMR_VALID);
    wr_reg(`USIS_OFS_IER, 32'h20);
    pulse(1);
    for (i = 0; i < 8 && irq !== 1'b1; i = i + 1)
      @(negedge sys_clk);
    check({31'h0, irq}, 32'h1);
    wr_reg(`USIS_OFS_IDR, 32'h20);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    check({31'h0, irq}, 32'h0);
    usis_peer_i.set_pins(4'ha);
    chg = 4'ha;
    repeat (3) @(posedge sys_clk);
    rd_chk(`USIS_OFS_CSR, 32'h0);
    rd_chk(`USIS_OFS_CSR, 32'h0);
    wr_reg(`USIS_OFS_CMD, 32'h1 << `USIS_C_RXEN);
    usis_peer_i.send(9'h1a5, 1'b1);
    rxr = 32'h1;
    rd_chk(`USIS_OFS_CSR, 32'h0);
    check({31'h0, to_arm}, 32'h0);
    rd_chk(`USIS_OFS_RHR, 32'h81a5);
    rxr = 32'h0;
    rd_chk(`USIS_OFS_CSR, 32'h0);
    rx_active <= 1'b1;
    wr_reg(`USIS_OFS_CMD, 32'h1 << `USIS_C_RXDIS);
    rd_chk(`USIS_OFS_CSR, 32'h0);
    wr_reg(`USIS_OFS_CMD, 32'h1 << `USIS_C_RXEN);
    rxr = 32'h1;
    rd_chk(`USIS_OFS_CSR, 32'h0);
    wr_reg(`USIS_OFS_CMD, 32'h1 << `USIS_C_TXEN);
    tx_m = 32'h1;
    for (i = 0; i < 4; i = i + 1)
    begin
      {tx_hold, tx_shift} <= i[1:0];
      rd_chk(`USIS_OFS_CSR, 32'h0);
    end
    // Break pends behind a busy shifter, holds ready low, then fires once drained.
    wr_reg(`USIS_OFS_CMD, 32'h1 << `USIS_C_START_BREAK_COMMAND);
    tx_m = 32'h3;
    {tx_hold, tx_shift} <= 2'b01;
    rd_chk(`USIS_OFS_CSR, 32'h0);
    {tx_hold, tx_shift} <= 2'b00;
    for (i = 0; i < 8 && brk_req !== 1'b1; i = i + 1)
      @(negedge sys_clk);
    check({31'h0, brk_req}, 32'h1);
    tx_m = 32'h1;
    rd_chk(`USIS_OFS_CSR, 32'h0);
    rd_chk(`USIS_OFS_CTL, 32'h3);
    wr_reg(`USIS_OFS_CMD, 32'h1 << `USIS_C_RSTTX);
    tx_m = 32'h0;
    rd_chk(`USIS_OFS_CSR, 32'h0);
    rd_chk(`USIS_OFS_CTL, 32'h1);
    tally_and_finish;
  end
endmodule // usart_interrupt_status_test

// File: tb/usis_peer.sv
// Behavioural serial peer that delivers characters and moves the modem lines.
`timescale 1ns/1ps
// ==========================================================
// Peer
module usis_peer
(
  input wire clk,
  output reg done,
  output reg [8:0] chr,
  output reg sync,
  output reg [3:0] pins
);
  // Lines start quiet.
  initial
  begin
    done = 1'b0;
    chr = 9'h0;
    sync = 1'b0;
    pins = 4'h0;
  end
  // A character stands one clock; after it the bus is scrambled so stale data cannot pass.
  task send(input [8:0] c, input s);
  begin
    @(posedge clk);
    done <= 1'b1;
    chr <= c;
    sync <= s;
    @(posedge clk);
    done <= 1'b0;
    chr <= ~c;
    sync <= ~s;
  end
  endtask
  // Modem lines move at a clock edge.
  task set_pins(input [3:0] p);
  begin
    @(posedge clk);
    pins <= p;
  end
  endtask
endmodule // usis_peer

// File: tb/usis_properties.sv
// Concurrent checks on the ports of the interrupt and status block.
`timescale 1ns/1ps
`include "usis_defines.vh"
// ==========================================================
// Checker
module usis_props
(
  input wire SYS_CLK,
  input wire NRST,
  input wire [`USIS_ADDR_W-1:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire IRQ,
  input wire RX_CHAR_DONE,
  input wire OVERRUN_EVT,
  input wire MANCH_EVT,
  input wire [3:0] DMA_SIG,
  input wire [3:0] MODEM_PINS,
  input wire TO_ARM,
  input wire TX_ENABLED,
  input wire [`USIS_TO_W-1:0] TIMEOUT_VALUE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // A status read, and a cycle free of the reset-status command.
  sequence s_csr_rd;
    RD && ADDR == `USIS_OFS_CSR;
  endsequence
  sequence s_no_clr;
    !(WR && ADDR == `USIS_OFS_CMD && WDATA[`USIS_C_RESET_STATUS_COMMAND]);
  endsequence
  a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_dma_mirror: assert property (s_csr_rd |=> {RDATA[12:11], RDATA[4:3]} == $past(DMA_SIG))
    else $error("dma image wrong");
  a_modem_image: assert property ($stable(MODEM_PINS) [*3] ##0 s_csr_rd |=> RDATA[23:20] == $past(MODEM_PINS))
    else $error("modem image wrong");
  a_idr_irq_off: assert property (WR && ADDR == `USIS_OFS_IDR && WDATA == `USIS_IMR_VALID |=> ##1 !IRQ)
    else $error("interrupt stays high with all sources disabled");
  a_tmo_zero: assert property (TIMEOUT_VALUE == 16'h0 ##0 s_csr_rd |=> !RDATA[`USIS_B_TMO])
    else $error("timeout flag set with zero value");
  a_ovr_sticky: assert property (OVERRUN_EVT ##1 s_no_clr ##1 s_csr_rd |=> RDATA[`USIS_B_OVR])
    else $error("overrun flag lost");
  a_manch_sticky: assert property (MANCH_EVT ##1 s_no_clr ##1 s_csr_rd |=> RDATA[`USIS_B_MAN_CSR])
    else $error("manchester flag lost");
  a_arm_timeout: assert property (WR && ADDR == `USIS_OFS_CMD && WDATA[`USIS_C_START_TIMEOUT_COMMAND] && !RX_CHAR_DONE |=> TO_ARM)
    else $error("start timeout did not arm");
  a_tx_off: assert property (!TX_ENABLED ##0 s_csr_rd |=> !RDATA[1] && !RDATA[9])
    else $error("transmitter flags high while disabled");
endmodule // usis_props
bind usis_top usis_props usis_props_i
(
  .SYS_CLK(SYS_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
  .RX_CHAR_DONE(RX_CHAR_DONE), .OVERRUN_EVT(OVERRUN_EVT), .MANCH_EVT(MANCH_EVT), .DMA_SIG(DMA_SIG),
  .MODEM_PINS(MODEM_PINS), .TO_ARM(TO_ARM), .TX_ENABLED(TX_ENABLED), .TIMEOUT_VALUE(TIMEOUT_VALUE)
);
